// file: rbs_operand_select.sv
// right operand register and its source decoder
//
// Contract
// RULE1: code 1010 reads second stack entry
// RULE2: second entry maps rotation to cache plus one
// RULE3: second read needs fill count above one
// RULE4: code 0101 holds the operand register
// RULE5: code 1001 reads third stack entry
// RULE6: third entry maps rotation to cache plus two
// RULE7: third read needs fill count above two
// RULE8: code 1000 reads fourth stack entry
// RULE9: fourth entry maps rotation to cache plus three
// RULE10: fourth read needs fill count four
// RULE11: fill guards only while cache holds stack
// RULE12: code 1101 loads scratch a
// RULE13: code 1100 loads scratch b
// RULE14: code 0001 loads fill count, upper zero
// RULE15: code 1110 loads store bus word
// RULE16: code 0110 loads index register
// RULE17: code 0111 loads index if bit four
// RULE18: code 0010 loads stack limit
// RULE19: code 1011 reads first entry, direct mapping
// RULE20: code 0000 loads program limit
// RULE21: code 0100 loads pre-adder output
// RULE22: sixteen bit register captures at microcycle end
// RULE23: code 1111 and undefined codes do nothing
`default_nettype none
module rbs_operand_select
   import rbs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire rbs_pkg::rbs_word_t stack_cache_0,
   input wire rbs_pkg::rbs_word_t stack_cache_1,
   input wire rbs_pkg::rbs_word_t stack_cache_2,
   input wire rbs_pkg::rbs_word_t stack_cache_3,
   input wire rbs_pkg::rbs_rot_t stack_rotation,
   input wire rbs_pkg::rbs_word_t scratch_a,
   input wire rbs_pkg::rbs_word_t scratch_b,
   input wire rbs_pkg::rbs_word_t store_bus_word,
   input wire rbs_pkg::rbs_word_t index_reg,
   input wire rbs_pkg::rbs_word_t current_instr_reg,
   input wire rbs_pkg::rbs_word_t stack_limit_reg,
   input wire rbs_pkg::rbs_word_t program_limit_reg,
   input wire rbs_pkg::rbs_word_t pre_adder,
   output rbs_pkg::rbs_word_t right_operand,
   output rbs_pkg::rbs_rot_t effective_rotation,
   rbs_if.device bus
);
   import rbs_pkg::*;

   rbs_word_t cache [4];
   rbs_word_t operand_ff;
   rbs_word_t nxt_operand;
   logic load;
   rbs_rot_t offset;
   rbs_rot_t slot;

   assign cache[0] = stack_cache_0;
   assign cache[1] = stack_cache_1;
   assign cache[2] = stack_cache_2;
   assign cache[3] = stack_cache_3;

   // ----------------------------------------------------------------
   // stack entry addressing
   // ----------------------------------------------------------------
   // entry depth is added to the rotation; wrap of the 2-bit sum is the ring
   assign effective_rotation = stack_rotation; // [RULE1] [RULE5] [RULE8] [RULE19]

   always_comb begin
      case (bus.field_code)
         RBS_STACK_SECOND: offset = 2'h1; // [RULE2]
         RBS_STACK_THIRD: offset = 2'h2; // [RULE6]
         RBS_STACK_FOURTH: offset = 2'h3; // [RULE9]
         default: offset = 2'h0; // [RULE19]
      endcase
   end

   assign slot = rbs_rot_t'(effective_rotation + offset);

   // ----------------------------------------------------------------
   // source decode
   // ----------------------------------------------------------------
   // the memory register code is not decoded here and leaves the register alone
   always_comb begin
      load = 1'b1;
      nxt_operand = operand_ff;
      case (bus.field_code)
         RBS_STACK_FIRST,
         RBS_STACK_SECOND,
         RBS_STACK_THIRD,
         RBS_STACK_FOURTH: nxt_operand = cache[slot]; // [RULE1] [RULE5] [RULE8]
         RBS_SCRATCH_A: nxt_operand = scratch_a; // [RULE12]
         RBS_SCRATCH_B: nxt_operand = scratch_b; // [RULE13]
         RBS_FILL_COUNT: nxt_operand = {13'h0, bus.stack_fill_count}; // [RULE14]
         RBS_STORE_BUS: nxt_operand = store_bus_word; // [RULE15]
         RBS_INDEX: nxt_operand = index_reg; // [RULE16]
         RBS_COND_INDEX: begin
            if (current_instr_reg[RBS_IDX_BIT]) begin // [RULE17]
               nxt_operand = index_reg;
            end else begin
               nxt_operand = RBS_RESET_VAL;
            end
         end
         RBS_STACK_LIMIT: nxt_operand = stack_limit_reg; // [RULE18]
         RBS_PROGRAM_LIMIT: nxt_operand = program_limit_reg; // [RULE20]
         RBS_PRE_ADDER: nxt_operand = pre_adder; // [RULE21]
         RBS_HOLD: load = 1'b0; // [RULE4]
         default: load = 1'b0; // [RULE23]
      endcase
   end

   // ----------------------------------------------------------------
   // right operand register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         operand_ff <= RBS_RESET_VAL;
      end else if (load) begin
         operand_ff <= nxt_operand; // [RULE22]
      end
   end

   assign right_operand = operand_ff;
endmodule
`default_nettype wire

// file: rbs_pkg.sv
// shared constants and types for the right operand source selector
`default_nettype none
package rbs_pkg;
   localparam int unsigned RBS_DATA_W = 16;
   localparam int unsigned RBS_CODE_W = 4;
   localparam int unsigned RBS_FILL_W = 3;
   localparam int unsigned RBS_ROT_W = 2;
   localparam int unsigned RBS_IDX_BIT = 4;
   localparam logic [15:0] RBS_RESET_VAL = 16'h0000;
   localparam logic [2:0] RBS_READ_FIRST_MIN = 3'h1;
   localparam logic [2:0] RBS_READ_SECOND_MIN = 3'h2;
   localparam logic [2:0] RBS_READ_THIRD_MIN = 3'h3;
   localparam logic [2:0] RBS_READ_FOURTH_EQ = 3'h4;

   typedef logic [15:0] rbs_word_t;
   typedef logic [1:0] rbs_rot_t;

   typedef enum logic [3:0] {
      RBS_PROGRAM_LIMIT = 4'h0,
      RBS_FILL_COUNT = 4'h1,
      RBS_STACK_LIMIT = 4'h2,
      RBS_MEM_REG = 4'h3,
      RBS_PRE_ADDER = 4'h4,
      RBS_HOLD = 4'h5,
      RBS_INDEX = 4'h6,
      RBS_COND_INDEX = 4'h7,
      RBS_STACK_FOURTH = 4'h8,
      RBS_STACK_THIRD = 4'h9,
      RBS_STACK_SECOND = 4'ha,
      RBS_STACK_FIRST = 4'hb,
      RBS_SCRATCH_B = 4'hc,
      RBS_SCRATCH_A = 4'hd,
      RBS_STORE_BUS = 4'he,
      RBS_NOP = 4'hf
   } rbs_code_t;
endpackage
`default_nettype wire

// file: rbs_if.sv
// interface between the microinstruction register and the operand selector
`default_nettype none
interface rbs_if
   import rbs_pkg::*;
();
   rbs_code_t field_code;
   logic [2:0] stack_fill_count;
   logic stack_in_use;
   modport device (
      input field_code,
      input stack_fill_count,
      input stack_in_use
   );
   modport host (
      output field_code,
      output stack_fill_count,
      output stack_in_use
   );
endinterface
`default_nettype wire

// file: rbs_microprogram.sv
// microprogram side: drives the field code and guards stack reads
`default_nettype none
module rbs_microprogram
   import rbs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire rbs_pkg::rbs_code_t req_code,
   input wire logic req_valid,
   input wire logic [2:0] fill_count_in,
   input wire logic stack_in_use_in,
   output logic req_refused,
   rbs_if.host bus
);
   import rbs_pkg::*;

   logic allowed;
   rbs_code_t code_ff;
   logic refused_ff;

   // ----------------------------------------------------------------
   // fill count guard for stack reads
   // ----------------------------------------------------------------
   // scratch use of the cache needs no fill guard
   always_comb begin
      allowed = 1'b1;
      if (stack_in_use_in) begin // [RULE11]
         case (req_code)
            RBS_STACK_FIRST: allowed = fill_count_in >= RBS_READ_FIRST_MIN;
            RBS_STACK_SECOND: allowed = fill_count_in >= RBS_READ_SECOND_MIN; // [RULE3]
            RBS_STACK_THIRD: allowed = fill_count_in >= RBS_READ_THIRD_MIN; // [RULE7]
            RBS_STACK_FOURTH: allowed = fill_count_in == RBS_READ_FOURTH_EQ; // [RULE10]
            default: allowed = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // microinstruction register
   // ----------------------------------------------------------------
   // a refused request becomes a nop so the operand register holds still
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         code_ff <= RBS_NOP;
      end else if (req_valid && allowed) begin
         code_ff <= req_code;
      end else begin
         code_ff <= RBS_NOP;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         refused_ff <= 1'b0;
      end else begin
         refused_ff <= req_valid && !allowed;
      end
   end

   assign req_refused = refused_ff;
   assign bus.field_code = code_ff;
   assign bus.stack_fill_count = fill_count_in;
   assign bus.stack_in_use = stack_in_use_in;
endmodule
`default_nettype wire

// file: rbs_link_properties.sv
// timing checks on the link between microprogram and operand selector
`default_nettype none
module rbs_link_properties
   import rbs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire rbs_pkg::rbs_code_t field_code,
   input wire logic [2:0] stack_fill_count,
   input wire logic stack_in_use,
   input wire rbs_pkg::rbs_word_t right_operand
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // a code on the link was granted against last cycle's fill, hence the $past
   chk_second_guard: assert property (
      field_code == RBS_STACK_SECOND && $past(stack_in_use) |-> $past(stack_fill_count) > 3'h1)
      else $error("second entry read on short stack");
   chk_third_guard: assert property (
      field_code == RBS_STACK_THIRD && $past(stack_in_use) |-> $past(stack_fill_count) > 3'h2)
      else $error("third entry read on short stack");
   chk_fourth_guard: assert property (
      field_code == RBS_STACK_FOURTH && $past(stack_in_use) |-> $past(stack_fill_count) == 3'h4)
      else $error("fourth entry read on partial stack");
   // the operand register answers one edge after the code is seen on the link
   chk_hold_keeps: assert property (
      field_code == RBS_HOLD |=> $stable(right_operand))
      else $error("hold code changed the operand register");
   chk_idle_keeps: assert property (
      field_code == RBS_NOP || field_code == RBS_MEM_REG |=> $stable(right_operand))
      else $error("idle code changed the operand register");
   chk_fill_load: assert property (
      field_code == RBS_FILL_COUNT |=> right_operand == {13'h0, $past(stack_fill_count)})
      else $error("fill count load wrong");
   cover property (field_code == RBS_STACK_FOURTH && !stack_in_use);
   cover property (field_code == RBS_STACK_THIRD && stack_in_use);
   cover property (field_code == RBS_HOLD);
endmodule
`default_nettype wire

// file: rbus_source_select_tb_top.sv
// random and corner stimulus for both ends of the operand link
`default_nettype none
module rbus_source_select_tb_top
   import rbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic req_valid = 1'b0;
   logic in_use = 1'b0;
   logic refused;
   logic exp_ref;
   logic [2:0] fill = 3'h0;
   rbs_rot_t rot = 2'h0;
   rbs_rot_t eff_rot;
   rbs_code_t req = RBS_NOP;
   rbs_code_t exp_code = RBS_NOP;
   rbs_word_t src [12] = '{default: 16'h0000};
   rbs_word_t opnd;
   rbs_word_t exp_op = RBS_RESET_VAL;
   logic [31:0] seed = 32'hffa7;
   int err_count = 0;
   int n_compared = 0;
   rbs_if link ();
   always #50 sys_clk = ~sys_clk;
   rbs_microprogram rbs_microprogram_inst (.sys_clk(sys_clk), .rst_b(rst_b), .req_code(req),
      .req_valid(req_valid), .fill_count_in(fill), .stack_in_use_in(in_use),
      .req_refused(refused), .bus(link.host));
   rbs_operand_select rbs_operand_select_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .stack_cache_0(src[0]), .stack_cache_1(src[1]), .stack_cache_2(src[2]),
      .stack_cache_3(src[3]), .stack_rotation(rot), .scratch_a(src[4]), .scratch_b(src[5]),
      .store_bus_word(src[6]), .index_reg(src[7]), .current_instr_reg(src[8]),
      .stack_limit_reg(src[9]), .program_limit_reg(src[10]), .pre_adder(src[11]),
      .right_operand(opnd), .effective_rotation(eff_rot), .bus(link.device));
   rbs_link_properties rbs_link_properties_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .field_code(link.field_code), .stack_fill_count(link.stack_fill_count),
      .stack_in_use(link.stack_in_use), .right_operand(opnd));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // stack guards apply only while the cache holds stack
   function automatic logic ok(input rbs_code_t c);
      case (c)
         4'hb: return !in_use || fill > 3'h0;
         4'ha: return !in_use || fill > 3'h1;
         4'h9: return !in_use || fill > 3'h2;
         4'h8: return !in_use || fill == 3'h4;
         default: return 1'b1;
      endcase
   endfunction
   function automatic rbs_word_t sel(input rbs_code_t c, input rbs_word_t hold);
      case (c)
         4'h0: return src[10];
         4'h1: return {13'h0, fill};
         4'h2: return src[9];
         4'h4: return src[11];
         4'h6: return src[7];
         4'h7: return src[8][RBS_IDX_BIT] ? src[7] : 16'h0000;
         4'h8: return src[rbs_rot_t'(rot + 2'h3)];
         4'h9: return src[rbs_rot_t'(rot + 2'h2)];
         4'ha: return src[rbs_rot_t'(rot + 2'h1)];
         4'hb: return src[rot];
         4'hc: return src[5];
         4'hd: return src[4];
         4'he: return src[6];
         default: return hold;
      endcase
   endfunction
   task automatic cmp(input string what, input rbs_word_t exp, input rbs_word_t got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // first 48 requests walk every code, scratch use first, then a live stack
   initial begin
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp("reset operand", RBS_RESET_VAL, opnd);
      rst_b = 1'b1;
      for (int i = 0; i < 800; i++) begin
         @(negedge sys_clk);
         exp_op = sel(exp_code, exp_op);
         exp_ref = req_valid && !ok(req);
         exp_code = (req_valid && !exp_ref) ? req : RBS_NOP;
         cmp("operand", exp_op, opnd);
         cmp("code", {12'h000, exp_code}, {12'h000, link.field_code});
         cmp("refused", {15'h0, exp_ref}, {15'h0, refused});
         cmp("rotation", {14'h0, rot}, {14'h0, eff_rot});
         seed = xs(seed);
         req = rbs_code_t'(i < 48 ? i[3:0] : seed[3:0]);
         req_valid = i < 48 || seed[4];
         in_use = i > 15 && (i < 48 || seed[5]);
         fill = seed[8:6] > 3'h4 ? 3'h4 : seed[8:6];
         rot = seed[10:9];
         foreach (src[k]) begin
            seed = xs(seed);
            src[k] = seed[15:0];
         end
      end
      print_verdict();
   end
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
